// ==== src/dsr_pkg.sv ====
// Constants, types and sense codes for the disk sense code reporter
// Functional notes
// R1: No error reports zero, last address
// R2: Format without index in 3 s
// R3: No seek complete within 3 s
// R4: Fault during write or format
// R5: Drive not selected or not ready
// R6: No track zero after cylinders+5 steps
// R7: Multiple drive selected indications seen
// R8: In-progress code only for unit ready
// R9: Removable medium swapped since last access
// R10: ID CRC only on format check
// R11: Uncorrectable ECC withholds sector, ends command
// R12: Missing ID mark versus missing data mark
// R13: Recorded cylinder/head mismatch is seek error
// R14: Sequencer or DMA overrun code
// R15: Write protect during write or format
// R16: Correctable ECC ends only when correction disabled
// R17: Bad-track flag refuses access
// R18: Interleave too large or mismatched
// R19: Alternate access and already-assigned codes
// R20: Missing alternate flag, self-assigned alternate
// R21: Command-class codes and volume overflow
// R22: Buffer RAM and firmware diagnostic codes
// R23: Byte 0: valid flag, class, code
// R24: Request sense returns four bytes
// R25: Sense kept per unit until overwritten
package dsr_pkg;
	localparam int DSR_CLK_HZ = 125000000;
	localparam int DSR_TIMEOUT_S = 3;
	localparam int DSR_TIMEOUT_CYC = DSR_CLK_HZ * DSR_TIMEOUT_S;
	localparam int DSR_STEP_SLACK = 5;
	localparam int DSR_SENSE_BYTES = 4;
	localparam int DSR_AV_BIT = 7;
	localparam int DSR_LUN_LO = 5;

	// Sense codes: upper two bits are the error class
	localparam logic [5:0] SC_NONE = 6'h00;
	localparam logic [5:0] SC_NO_INDEX = 6'h01;
	localparam logic [5:0] SC_NO_SEEK_CMPL = 6'h02;
	localparam logic [5:0] SC_WRITE_FAULT = 6'h03;
	localparam logic [5:0] SC_NOT_READY = 6'h04;
	localparam logic [5:0] SC_NO_TRACK0 = 6'h06;
	localparam logic [5:0] SC_MULTI_SEL = 6'h07;
	localparam logic [5:0] SC_IN_PROGRESS = 6'h08;
	localparam logic [5:0] SC_CART_CHANGED = 6'h09;
	localparam logic [5:0] SC_ID_CRC = 6'h10;
	localparam logic [5:0] SC_UNCORR_ECC = 6'h11;
	localparam logic [5:0] SC_NO_ID_MARK = 6'h12;
	localparam logic [5:0] SC_NO_DATA_MARK = 6'h13;
	localparam logic [5:0] SC_NOT_FOUND = 6'h14;
	localparam logic [5:0] SC_SEEK_ERR = 6'h15;
	localparam logic [5:0] SC_SEQ_DMA = 6'h16;
	localparam logic [5:0] SC_WRITE_PROT = 6'h17;
	localparam logic [5:0] SC_CORR_ECC = 6'h18;
	localparam logic [5:0] SC_BAD_TRACK = 6'h19;
	localparam logic [5:0] SC_BAD_INTERLV = 6'h1a;
	localparam logic [5:0] SC_ALT_ACCESS = 6'h1c;
	localparam logic [5:0] SC_ALT_ASSIGNED = 6'h1d;
	localparam logic [5:0] SC_NO_ALT = 6'h1e;
	localparam logic [5:0] SC_ALT_SELF = 6'h1f;
	localparam logic [5:0] SC_BAD_CMD = 6'h20;
	localparam logic [5:0] SC_BAD_ADDR = 6'h21;
	localparam logic [5:0] SC_BAD_FUNC = 6'h22;
	localparam logic [5:0] SC_VOL_OVF = 6'h23;
	localparam logic [5:0] SC_RAM_ERR = 6'h30;
	localparam logic [5:0] SC_FW_ERR = 6'h31;

	// Sector address as carried in sense bytes 1 to 3
	typedef struct packed {
		logic [10:0] cyl;
		logic [4:0] head;
		logic [5:0] sector;
	} dsr_addr_t;

	// Operation kinds the command sequencer reports
	typedef struct packed {
		logic fmt;
		logic fmt_check;
		logic write;
		logic read;
		logic recal;
		logic unit_ready;
		logic alt_assign;
	} dsr_op_t;

	// Drive interface indications, asynchronous to ref_clk
	typedef struct packed {
		logic index;
		logic seek_cmpl;
		logic fault;
		logic selected;
		logic ready;
		logic track0;
		logic multi_sel;
		logic write_prot;
		logic medium_swap;
	} dsr_drv_t;

	// Data path findings, synchronous, pulses
	typedef struct packed {
		logic id_crc;
		logic ecc_uncorr;
		logic ecc_corr;
		logic no_id_mark;
		logic no_data_mark;
		logic not_found;
		logic chs_mismatch;
		logic seq_overrun;
		logic bad_track_flag;
		logic interlv_bad;
		logic alt_direct;
		logic alt_unreadable;
		logic alt_dest_used;
		logic alt_flag_missing;
		logic alt_same;
		logic bad_opcode;
		logic addr_range;
		logic cart_on_fixed;
		logic end_volume;
		logic ram_err;
		logic fw_err;
	} dsr_det_t;

	typedef struct packed {
		logic [5:0] code;
		logic addr_valid;
		dsr_addr_t addr;
	} dsr_sense_t;
endpackage

// ==== src/dsr_sense_mem.sv ====
// Per-unit sense memory with registered read data
`timescale 1ns/1ps
module dsr_sense_mem #(
	parameter int LUN_W = 1,
	parameter int DW = 29
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [LUN_W-1:0] wr_lun,
	input wire logic [DW-1:0] wr_data,
	input wire logic [LUN_W-1:0] rd_lun,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem_reg [2**LUN_W];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 2**LUN_W; i++) begin
				mem_reg[i] <= '0;
			end
			rd_data <= '0;
		end else begin
			if (wr_en) begin
				mem_reg[wr_lun] <= wr_data;
			end
			rd_data <= mem_reg[rd_lun];
		end
	end
endmodule // dsr_sense_mem

// ==== src/dsr_reporter.sv ====
// Sense code classification and request-sense byte delivery
`timescale 1ns/1ps
module dsr_reporter #(
	parameter int TIMEOUT_CYC = dsr_pkg::DSR_TIMEOUT_CYC,
	parameter int LUN_W = 1,
	parameter int CYL_W = 11
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmd_start,
	input wire logic [LUN_W-1:0] cmd_lun,
	input wire dsr_pkg::dsr_op_t cmd_op,
	input wire logic removable,
	input wire logic ecc_corr_disable,
	input wire logic [CYL_W-1:0] cyl_count,
	input wire logic step_pulse,
	input wire logic cmd_done,
	input wire dsr_pkg::dsr_addr_t cur_addr,
	input wire dsr_pkg::dsr_drv_t drv_in,
	input wire dsr_pkg::dsr_det_t det,
	input wire logic sense_req,
	input wire logic [LUN_W-1:0] sense_lun,
	output logic cmd_abort,
	output logic withhold_sector,
	output logic error_status,
	output logic [7:0] sense_byte,
	output logic sense_valid,
	output logic sense_last
);
	import dsr_pkg::*;

	typedef enum {ST_IDLE, ST_RUN, ST_FETCH, ST_WAIT, ST_SEND} dsr_state_t;

	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] T_LIMIT = TW'(TIMEOUT_CYC);
	localparam logic [2:0] LAST_IDX = 3'(DSR_SENSE_BYTES - 1);
	localparam int DRV_W = $bits(dsr_drv_t);
	localparam int MEM_W = $bits(dsr_sense_t);

	dsr_state_t state_reg, state_next;
	logic [DRV_W-1:0] sync1_reg, sync2_reg;
	dsr_drv_t drv;
	logic [TW-1:0] tmr_reg;
	logic [CYL_W+2:0] steps_reg;
	logic [LUN_W-1:0] lun_reg;
	dsr_op_t op_reg;
	logic [2:0] idx_reg;
	logic idx_seen_reg, seek_seen_reg;
	logic [LUN_W-1:0] busy_lun_reg;
	logic busy_reg;
	logic [2**LUN_W-1:0] swap_reg;
	logic [5:0] hit_code;
	logic hit;
	logic wr_en;
	dsr_sense_t wr_sense, rd_sense;
	logic [LUN_W-1:0] rd_lun;
	logic [7:0] byte_sel;
	logic [7:0] lun_byte;
	logic timeout;
	logic [CYL_W+2:0] step_limit;

	// Two-stage synchroniser for drive pins
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= drv_in;
			sync2_reg <= sync1_reg;
		end
	end
	assign drv = dsr_drv_t'(sync2_reg);

	assign timeout = (tmr_reg == T_LIMIT);
	assign step_limit = (CYL_W+3)'(cyl_count) + (CYL_W+3)'(DSR_STEP_SLACK);
	wire wr_op = op_reg.write | op_reg.fmt;
	wire run = (state_reg == ST_RUN);
	wire drive_bad = drv.multi_sel | !drv.selected | !drv.ready;

	// Priority encoder: first detected condition wins one code
	always_comb begin
		hit_code = SC_NONE;
		hit = 1'b1;
		if (drv.multi_sel) hit_code = SC_MULTI_SEL; // [R7]
		else if (!drv.selected || !drv.ready) hit_code = SC_NOT_READY; // [R5]
		else if (removable && swap_reg[lun_reg]) hit_code = SC_CART_CHANGED; // [R9]
		else if (wr_op && drv.write_prot) hit_code = SC_WRITE_PROT; // [R15]
		else if (wr_op && drv.fault) hit_code = SC_WRITE_FAULT; // [R4]
		else if (op_reg.fmt && !idx_seen_reg && timeout) hit_code = SC_NO_INDEX; // [R2]
		else if (!op_reg.fmt && !seek_seen_reg && timeout) hit_code = SC_NO_SEEK_CMPL; // [R3]
		else if (op_reg.recal && steps_reg >= step_limit && !drv.track0) begin
			hit_code = SC_NO_TRACK0; // [R6]
		end
		else if (det.seq_overrun) hit_code = SC_SEQ_DMA; // [R14]
		else if (det.id_crc) hit_code = op_reg.fmt_check ? SC_ID_CRC : SC_NOT_FOUND; // [R10]
		else if (det.ecc_uncorr) hit_code = SC_UNCORR_ECC; // [R11]
		else if (det.no_id_mark) hit_code = SC_NO_ID_MARK; // [R12]
		else if (det.no_data_mark) hit_code = SC_NO_DATA_MARK; // [R12]
		else if (det.not_found) hit_code = SC_NOT_FOUND;
		else if (det.chs_mismatch) hit_code = SC_SEEK_ERR; // [R13]
		else if (det.ecc_corr && ecc_corr_disable) hit_code = SC_CORR_ECC; // [R16]
		else if (det.bad_track_flag) hit_code = SC_BAD_TRACK; // [R17]
		else if (det.interlv_bad) hit_code = SC_BAD_INTERLV; // [R18]
		else if (det.alt_direct || det.alt_unreadable) hit_code = SC_ALT_ACCESS; // [R19]
		else if (det.alt_dest_used) hit_code = SC_ALT_ASSIGNED; // [R19]
		else if (det.alt_flag_missing) hit_code = SC_NO_ALT; // [R20]
		else if (det.alt_same) hit_code = SC_ALT_SELF; // [R20]
		else if (det.bad_opcode) hit_code = SC_BAD_CMD; // [R21]
		else if (det.addr_range) hit_code = SC_BAD_ADDR; // [R21]
		else if (det.cart_on_fixed) hit_code = SC_BAD_FUNC; // [R21]
		else if (det.end_volume) hit_code = SC_VOL_OVF; // [R21]
		else if (det.ram_err) hit_code = SC_RAM_ERR; // [R22]
		else if (det.fw_err) hit_code = SC_FW_ERR; // [R22]
		else hit = 1'b0;
	end

	// A busy unit answers a unit-ready test with in-progress only
	wire ready_busy = cmd_start && cmd_op.unit_ready && busy_reg
		&& (busy_lun_reg == cmd_lun); // [R8]

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_start && !ready_busy) state_next = ST_RUN;
				else if (sense_req) state_next = ST_FETCH;
			end
			ST_RUN: begin
				if (hit || cmd_done) state_next = ST_IDLE;
			end
			ST_FETCH: state_next = ST_WAIT;
			ST_WAIT: state_next = ST_SEND;
			ST_SEND: begin
				if (idx_reg == LAST_IDX) state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Command context and timers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lun_reg <= '0;
			op_reg <= '0;
			tmr_reg <= '0;
			steps_reg <= '0;
			idx_seen_reg <= 1'b0;
			seek_seen_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && cmd_start && !ready_busy) begin
			lun_reg <= cmd_lun;
			op_reg <= cmd_op;
			tmr_reg <= '0;
			steps_reg <= '0;
			idx_seen_reg <= 1'b0;
			seek_seen_reg <= 1'b0;
		end else if (run) begin
			if (!timeout) tmr_reg <= tmr_reg + 1'b1;
			if (step_pulse && !drv.track0) steps_reg <= steps_reg + 1'b1; // [R6]
			if (drv.index) idx_seen_reg <= 1'b1;
			if (drv.seek_cmpl) seek_seen_reg <= 1'b1;
		end
	end

	// Busy tracking for the in-progress answer
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_reg <= 1'b0;
			busy_lun_reg <= '0;
		end else if (state_reg == ST_IDLE && cmd_start && !ready_busy) begin
			busy_reg <= !cmd_op.unit_ready;
			busy_lun_reg <= cmd_lun;
		end else if (run && (hit || cmd_done)) begin
			busy_reg <= 1'b0; // [R8]
		end
	end

	// Medium swap sticky per unit; the swap event wins over the access clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			swap_reg <= '0;
		end else begin
			if (run && (hit || cmd_done)) swap_reg[lun_reg] <= 1'b0;
			if (drv.medium_swap) swap_reg[lun_reg] <= 1'b1; // [R9]
		end
	end

	// Write the result of a finished command into its unit slot; an in-progress answer in the same cycle takes that slot instead
	assign wr_en = ready_busy || (run && (hit || cmd_done)); // [R25]
	assign wr_sense.code = ready_busy ? SC_IN_PROGRESS : (hit ? hit_code : SC_NONE); // [R1]
	assign wr_sense.addr_valid = !ready_busy && !drive_bad;
	assign wr_sense.addr = cur_addr; // [R1]
	assign rd_lun = sense_lun;

	dsr_sense_mem #(.LUN_W(LUN_W), .DW(MEM_W)) u_mem (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.wr_lun(ready_busy ? cmd_lun : lun_reg),
		.wr_data(wr_sense),
		.rd_lun(rd_lun),
		.rd_data(rd_sense)
	);

	// Outputs to the sequencer
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_abort <= 1'b0;
			withhold_sector <= 1'b0;
			error_status <= 1'b0;
		end else begin
			cmd_abort <= run && hit; // [R11] [R16] [R17]
			withhold_sector <= run && hit && (hit_code == SC_UNCORR_ECC); // [R11]
			if (wr_en) error_status <= (wr_sense.code != SC_NONE); // [R24]
		end
	end

	// Wider unit numbers spill into bit 6 and above
	assign lun_byte = 8'(8'(sense_lun) << DSR_LUN_LO);

	// Sense byte layout
	always_comb begin
		case (idx_reg)
			3'd0: byte_sel = {rd_sense.addr_valid, 1'b0, rd_sense.code}; // [R23]
			3'd1: byte_sel = {rd_sense.addr.cyl[10], 2'b00, rd_sense.addr.head} | lun_byte;
			3'd2: byte_sel = {rd_sense.addr.cyl[9:8], rd_sense.addr.sector};
			3'd3: byte_sel = rd_sense.addr.cyl[7:0];
			default: byte_sel = 8'h00;
		endcase
	end

	// Four sense bytes, one per cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_reg <= '0;
			sense_byte <= '0;
			sense_valid <= 1'b0;
			sense_last <= 1'b0;
		end else begin
			sense_valid <= (state_reg == ST_SEND); // [R24]
			sense_last <= (state_reg == ST_SEND) && (idx_reg == LAST_IDX);
			sense_byte <= (state_reg == ST_SEND) ? byte_sel : 8'h00;
			if (state_reg == ST_SEND) idx_reg <= idx_reg + 1'b1;
			else idx_reg <= '0;
		end
	end
endmodule // dsr_reporter

// ==== tb/dsr_reporter_assertions.sv ====
// Port-level checker for the sense code reporter
`timescale 1ns/1ps
module dsr_reporter_assertions
	import dsr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ecc_corr_disable,
	input wire dsr_pkg::dsr_drv_t drv_in,
	input wire dsr_pkg::dsr_det_t det,
	input wire logic sense_req,
	input wire logic cmd_abort,
	input wire logic withhold_sector,
	input wire logic error_status,
	input wire logic [7:0] sense_byte,
	input wire logic sense_valid,
	input wire logic sense_last
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_body;
		(sense_valid && !sense_last) [*3] ##1 (sense_valid && sense_last);
	endsequence
	property p_four_bytes;
		$rose(sense_valid) |-> s_body ##1 !sense_valid;
	endproperty
	a_four_bytes: assert property (p_four_bytes) else $error("sense burst length wrong");
	property p_last_valid;
		sense_last |-> sense_valid;
	endproperty
	a_last_valid: assert property (p_last_valid) else $error("last byte not valid");
	property p_req_lat;
		$rose(sense_valid) |-> $past(sense_req, 3) || $past(sense_req, 4);
	endproperty
	a_req_lat: assert property (p_req_lat) else $error("sense burst without request");
	property p_byte0;
		$rose(sense_valid) |-> !sense_byte[6];
	endproperty
	a_byte0: assert property (p_byte0) else $error("sense byte 0 bit 6 set");
	property p_abort_pulse;
		cmd_abort |=> !cmd_abort;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
	property p_withhold;
		withhold_sector |-> cmd_abort;
	endproperty
	a_withhold: assert property (p_withhold) else $error("withhold without abort");
	property p_err;
		cmd_abort |-> ##[0:1] error_status;
	endproperty
	a_err: assert property (p_err) else $error("abort without error status");
	property p_corr_silent;
		det == dsr_det_t'(21'h040000) && !ecc_corr_disable && $stable(drv_in) |=> !cmd_abort;
	endproperty
	a_corr_silent: assert property (p_corr_silent) else $error("silent correction aborted");
endmodule // dsr_reporter_assertions
bind dsr_reporter dsr_reporter_assertions i_dsr_chk (.ref_clk(ref_clk), .arst_n(arst_n),
	.ecc_corr_disable(ecc_corr_disable), .drv_in(drv_in), .det(det), .sense_req(sense_req),
	.cmd_abort(cmd_abort), .withhold_sector(withhold_sector), .error_status(error_status),
	.sense_byte(sense_byte), .sense_valid(sense_valid), .sense_last(sense_last));

// ==== tb/dsr_host_model.sv ====
// Host side model that issues request sense and gathers the bytes
`timescale 1ns/1ps
module dsr_host_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic lun,
	input wire logic [7:0] sense_byte,
	input wire logic sense_valid,
	input wire logic sense_last,
	output logic sense_req,
	output logic sense_lun,
	output logic [31:0] got,
	output int nbytes,
	output logic done
);
	logic fin;
	initial begin
		sense_req = 1'b0;
		sense_lun = 1'b0;
		got = '0;
		nbytes = 0;
		done = 1'b0;
	end
	always begin
		@(posedge ref_clk);
		if (go === 1'b1) begin
			done <= 1'b0;
			nbytes <= 0;
			sense_lun <= lun;
			sense_req <= 1'b1;
			@(posedge ref_clk);
			sense_req <= 1'b0;
			fin = 1'b0;
			for (int i = 0; i < 12 && !fin; i++) begin
				@(posedge ref_clk);
				if (sense_valid === 1'b1) begin
					got <= {got[23:0], sense_byte};
					nbytes <= nbytes + 1;
					fin = sense_last;
				end
			end
			done <= 1'b1;
		end
	end
endmodule // dsr_host_model

// ==== tb/dsr_reporter_tb.sv ====
// Self-checking bench for the sense code reporter
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch at %0t: %h vs %h", $time, a, b); end end
module dsr_reporter_tb;
	import dsr_pkg::*;
	logic ref_clk = 0, arst_n = 0, cmd_start = 0, cmd_lun = 0, cmd_done = 0, ecc_dis = 0;
	logic go = 0, h_lun = 0, sense_req, sense_lun, cmd_abort, withhold_sector;
	logic error_status, sense_valid, sense_last, h_done;
	logic [7:0] sense_byte;
	logic [31:0] got;
	int nbytes, err_count = 0, samples_checked = 0, wh_cnt = 0, ab_cnt = 0;
	logic rem = 0, step = 0;
	dsr_op_t cmd_op = '0;
	dsr_drv_t drv_in = 9'h0b0;
	dsr_det_t det = '0;
	dsr_addr_t cur_addr = {11'h5a3, 5'h0d, 6'h21};
	logic [5:0] codes [21] = '{SC_FW_ERR, SC_RAM_ERR, SC_VOL_OVF, SC_BAD_FUNC, SC_BAD_ADDR,
		SC_BAD_CMD, SC_ALT_SELF, SC_NO_ALT, SC_ALT_ASSIGNED, SC_ALT_ACCESS, SC_ALT_ACCESS,
		SC_BAD_INTERLV, SC_BAD_TRACK, SC_SEQ_DMA, SC_SEEK_ERR, SC_NOT_FOUND, SC_NO_DATA_MARK,
		SC_NO_ID_MARK, SC_CORR_ECC, SC_UNCORR_ECC, SC_NOT_FOUND};
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (withhold_sector === 1'b1) wh_cnt++;
	always @(posedge ref_clk) if (cmd_abort === 1'b1) ab_cnt++;
	dsr_reporter #(.TIMEOUT_CYC(50)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.cmd_start(cmd_start), .cmd_lun(cmd_lun), .cmd_op(cmd_op), .removable(rem),
		.ecc_corr_disable(ecc_dis), .cyl_count(11'h020), .step_pulse(step),
		.cmd_done(cmd_done), .cur_addr(cur_addr), .drv_in(drv_in), .det(det),
		.sense_req(sense_req), .sense_lun(sense_lun), .cmd_abort(cmd_abort),
		.withhold_sector(withhold_sector), .error_status(error_status),
		.sense_byte(sense_byte), .sense_valid(sense_valid), .sense_last(sense_last));
	dsr_host_model i_host (.ref_clk(ref_clk), .go(go), .lun(h_lun), .sense_byte(sense_byte),
		.sense_valid(sense_valid), .sense_last(sense_last), .sense_req(sense_req),
		.sense_lun(sense_lun), .got(got), .nbytes(nbytes), .done(h_done));
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Clean commands end on cmd_done; faulty ones must abort in bounded time
	task automatic do_cmd(input logic lun, input dsr_op_t op, input dsr_det_t d,
		input logic clean);
		int n;
		int ab0;
		ab0 = ab_cnt;
		@(posedge ref_clk);
		cmd_start <= 1'b1;
		cmd_lun <= lun;
		cmd_op <= op;
		@(posedge ref_clk);
		cmd_start <= 1'b0;
		repeat (3) @(posedge ref_clk);
		det <= d;
		cmd_done <= clean;
		@(posedge ref_clk);
		det <= '0;
		cmd_done <= 1'b0;
		for (n = 0; n < 200 && !(clean || ab_cnt != ab0); n++) @(posedge ref_clk);
		if (n == 200) begin
			err_count++;
			wrap_up();
		end
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic get_sense(input logic lun, input logic [7:0] exp0);
		int n;
		@(posedge ref_clk);
		go <= 1'b1;
		h_lun <= lun;
		@(posedge ref_clk);
		go <= 1'b0;
		// Let the host drop done from the previous burst first
		@(posedge ref_clk);
		for (n = 0; n < 40 && h_done !== 1'b1; n++) @(posedge ref_clk);
		if (n == 40) begin
			err_count++;
			wrap_up();
		end
		`CHK(nbytes, 4)
		`CHK(got[31:24], exp0)
	endtask
	task automatic t_clean();
		do_cmd(1'b0, 7'h08, '0, 1'b1);
		`CHK(error_status, 1'b0)
		get_sense(1'b0, 8'h80);
		`CHK(got, 32'h808d61a3)
		$display("test clean done");
	endtask
	task automatic t_findings();
		dsr_op_t op;
		ecc_dis <= 1'b1; // Correctable finding must end the command
		for (int i = 20; i >= 0; i--) begin
			op = (i == 11) ? 7'h20 : ((i == 8 || i == 6) ? 7'h01 : 7'h08);
			do_cmd(1'b0, op, dsr_det_t'(21'h1 << i), 1'b0);
			`CHK(error_status, 1'b1)
			get_sense(1'b0, {2'b10, codes[i]});
		end
		`CHK(wh_cnt, 1)
		do_cmd(1'b0, 7'h20, 21'h100000, 1'b0);
		get_sense(1'b0, 8'h90);
		ecc_dis <= 1'b0;
		$display("test findings done");
	endtask
	task automatic t_drive();
		dsr_drv_t tab [5] = '{9'h0b2, 9'h0f0, 9'h0a0, 9'h0b4, 9'h030};
		dsr_op_t ops [5] = '{7'h10, 7'h10, 7'h08, 7'h08, 7'h08};
		logic [7:0] exp [5] = '{8'h97, 8'h83, 8'h04, 8'h07, 8'h82};
		for (int i = 0; i < 5; i++) begin
			drv_in <= tab[i];
			do_cmd(1'b1, ops[i], '0, 1'b0);
			drv_in <= 9'h0b0;
			get_sense(1'b1, exp[i]);
		end
		get_sense(1'b0, 8'h90);
		$display("test drive done");
	endtask
	task automatic t_extra();
		do_cmd(1'b0, 7'h40, '0, 1'b0);
		get_sense(1'b0, 8'h81);
		step <= 1'b1;
		do_cmd(1'b0, 7'h04, '0, 1'b0);
		step <= 1'b0;
		get_sense(1'b0, 8'h86);
		rem <= 1'b1;
		drv_in <= 9'h0b1;
		repeat (4) @(posedge ref_clk);
		drv_in <= 9'h0b0;
		repeat (3) @(posedge ref_clk);
		do_cmd(1'b0, 7'h08, '0, 1'b0);
		get_sense(1'b0, 8'h89);
		rem <= 1'b0;
		do_cmd(1'b0, 7'h08, 21'h040000, 1'b1);
		`CHK(error_status, 1'b0)
		get_sense(1'b0, 8'h80);
		$display("test extra done");
	endtask
	// Unit-ready test while a read is still running
	task automatic t_busy();
		@(posedge ref_clk);
		cmd_start <= 1'b1;
		cmd_lun <= 1'b0;
		cmd_op <= 7'h08;
		@(posedge ref_clk);
		cmd_op <= 7'h02;
		@(posedge ref_clk);
		cmd_start <= 1'b0;
		@(posedge ref_clk);
		`CHK(error_status, 1'b1)
		cmd_done <= 1'b1;
		@(posedge ref_clk);
		cmd_done <= 1'b0;
		@(posedge ref_clk);
		`CHK(error_status, 1'b0)
		repeat (3) @(posedge ref_clk);
		$display("test busy done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_clean();
		t_findings();
		t_drive();
		t_extra();
		t_busy();
		wrap_up();
	end
endmodule // dsr_reporter_tb
